// ==== src/ped_pkg.sv ====
// constants, register map and encodings of the pin edge detect and filter block
package ped_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned NMI_DELAY_US = 10;
  localparam int unsigned NMI_DELAY_CYCLES = NMI_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FILTER_RUN = 4;
  localparam int unsigned FILTERED_PINS = 7;
  localparam logic [1:0] SLOW_DIV_LAST = 2'h3;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_NPC = 16'hff3b;
  localparam logic [15:0] IDX_EDGE_SEL0 = 16'hff3c;
  localparam logic [15:0] IDX_EDGE_SEL1 = 16'hff3d;
  localparam logic [15:0] IDX_FLAGS0 = 16'hff3e;
  localparam logic [15:0] IDX_FLAGS1 = 16'hff3f;
  localparam logic [31:0] ADDR_NPC = {14'h0000, IDX_NPC, 2'h0};
  localparam logic [31:0] ADDR_EDGE_SEL0 = {14'h0000, IDX_EDGE_SEL0, 2'h0};
  localparam logic [31:0] ADDR_EDGE_SEL1 = {14'h0000, IDX_EDGE_SEL1, 2'h0};
  localparam logic [31:0] ADDR_FLAGS0 = {14'h0000, IDX_FLAGS0, 2'h0};
  localparam logic [31:0] ADDR_FLAGS1 = {14'h0000, IDX_FLAGS1, 2'h0};

  localparam logic [7:0] NPC_RST = 8'h00;
  localparam logic [7:0] EDGE_SEL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] NPC_MASK = 8'h7f;
  localparam logic [7:0] EDGE_SEL0_MASK = 8'hfd;
  localparam logic [7:0] FLAGS1_MASK = 8'h3f;

  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [7:0] NMI_VECTOR = 8'h02;
  localparam logic [7:0] SLOT0_VECTOR = 8'h0c;
  localparam logic [7:0] SLOT1_VECTOR = 8'h0e;
  localparam logic [4:0] SLOT0_PRIO = 5'h03;
  localparam logic [4:0] SLOT1_PRIO = 5'h04;
  localparam logic [19:0] SLOT0_CTRL_WORD = 20'hfe0c;
  localparam logic [19:0] SLOT1_CTRL_WORD = 20'hfe0e;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// ==== src/ped_noise_filter.sv ====
// synchroniser and four-sample digital noise filter for one pin
`timescale 1ns/1ns
module ped_noise_filter #(
  parameter int unsigned RUN = ped_pkg::FILTER_RUN
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  input wire logic sample_en,
  output logic level_r
);
  logic sync1_r;
  logic sync2_r;
  logic [RUN-2:0] hist_r;
  logic [RUN-1:0] window;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
    end
  end

  assign window = {hist_r, sync2_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_r <= '0;
    end else if (sample_en) begin
      hist_r <= window[RUN-2:0];
    end
  end

  // level changes only after RUN identical samples in a row
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_r <= 1'b0;
    end else if (sample_en && &window) begin
      level_r <= 1'b1;
    end else if (sample_en && ~|window) begin
      level_r <= 1'b0;
    end
  end
endmodule

// ==== src/ped_nmi_delay.sv ====
// delay filter for the non-maskable pin, stands in for the analog delay line
`timescale 1ns/1ns
module ped_nmi_delay #(
  parameter int unsigned CYCLES = ped_pkg::NMI_DELAY_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  output logic level_r
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic sync1_r;
  logic sync2_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
    end
  end

  // any return to the old level restarts the wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      level_r <= 1'b0;
    end else if (sync2_r == level_r) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      level_r <= sync2_r;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
endmodule

// ==== src/ped_top.sv ====
// edge detection unit: pin filters, edge flags, requests and AHB-Lite registers
// How it works
// - edge flags set on every rising or falling edge; only valid edges request
// - pin high after reset release counts as a rising edge and sets its flag
// - filter select register, one rate bit per pin in bits 0..6, bit 7 zero
// - full rate rejects 3 clocks, accepts 4; quarter rejects 12, accepts 16
// - non-maskable pin passes a delay filter of about 10 us before detection
// - new level accepted after four identical successive samples, else noise
// - filter adds four sampling clocks between pin edge and detection
// - valid edges on a pin may be missed while its edge select is rewritten
// - non-maskable valid edge raises request with vector 02h
// - pin 0 request shares slot with timer 0 match 0; priority 3, vector 0ch
// - pin 1 request shares slot with timer 0 match 1; priority 4, vector 0eh
// - edge field 00 falling, 01 rising, 11 both, 10 none; nmi bit 0 fall 1 rise
// - stop and idle halt detection on filtered pins, non-maskable pin keeps on
// - pins 0..3 capture timer 0, pin 4 starts converter, 5 and 6 count clocks
// - second flag register holds pins 4..6 as fall/rise pairs, bits 6..7 zero
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
module ped_top #(
  parameter int unsigned PINS = ped_pkg::FILTERED_PINS,
  parameter int unsigned NMI_CYCLES = ped_pkg::NMI_DELAY_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic nmi_input_pin,
  input wire logic [6:0] filtered_input_pins,
  input wire logic standby_stop,
  input wire logic standby_idle,
  input wire logic timer0_match0_request,
  input wire logic timer0_match1_request,
  output logic nmi_request,
  output logic [6:0] ext_request_pin,
  output logic slot0_request,
  output logic slot1_request,
  output logic [7:0] nmi_vector,
  output logic [7:0] slot0_vector,
  output logic [7:0] slot1_vector,
  output logic [4:0] slot0_priority,
  output logic [4:0] slot1_priority,
  output logic [3:0] timer0_capture_trig,
  output logic adc_start_trig,
  output logic tmr2_count_clk,
  output logic tmr3_count_clk
);
  // register state
  logic [7:0] noise_filter_clock_select_r;
  logic [7:0] edge_sel0_r;
  logic [7:0] edge_sel1_r;
  logic [7:0] flags0_r;
  logic [5:0] flags1_r;

  // bus state
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic take;

  // detection state
  logic [1:0] div_r;
  logic slow_strobe;
  logic [PINS-1:0] level;
  logic [PINS-1:0] prev_r;
  logic [PINS-1:0] rise;
  logic [PINS-1:0] fall;
  logic [PINS-1:0] valid;
  logic [PINS-1:0] sel_busy;
  logic [PINS-1:0] sample_en;
  logic [2*PINS-1:0] pin_sel;
  logic [2*PINS-1:0] seen;
  logic [PINS-1:0] req_r;
  logic nmi_level;
  logic nmi_prev_r;
  logic nmi_req_r;
  logic nmi_sel_busy;
  logic nmi_valid;
  logic halted;
  logic slot0_r;
  logic slot1_r;

  // selected edge of a two-bit field; the prohibited code selects nothing
  function automatic logic edge_valid(input logic [1:0] sel, input logic r, input logic f);
    logic v;
    v = 1'b0;
    case (sel)
      ped_pkg::EDGE_FALL: v = f;
      ped_pkg::EDGE_RISE: v = r;
      ped_pkg::EDGE_BOTH: v = r | f;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] reg_addr);
    return a == reg_addr;
  endfunction

  // ---------------- bus slave ----------------
  // zero wait states: every transfer finishes in one data phase
  assign hreadyout = 1'b1;
  assign hresp = ped_pkg::HRESP_OKAY;
  // hrdata stands until the next read, so a master that waits still sees it
  assign hrdata = hrdata_r;
  assign take = hsel && hready && (htrans == ped_pkg::HTRANS_NONSEQ);

  // writes land one cycle late, once hwdata stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_r <= '0;
    end else if (take && hwrite) begin
      wr_addr_r <= haddr;
    end
  end

  // read data sampled at the address phase; unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (take && !hwrite) begin
      if (addr_is(haddr, ped_pkg::ADDR_NPC)) begin
        hrdata_r <= {24'h000000, noise_filter_clock_select_r};
      end else if (addr_is(haddr, ped_pkg::ADDR_EDGE_SEL0)) begin
        hrdata_r <= {24'h000000, edge_sel0_r};
      end else if (addr_is(haddr, ped_pkg::ADDR_EDGE_SEL1)) begin
        hrdata_r <= {24'h000000, edge_sel1_r};
      end else if (addr_is(haddr, ped_pkg::ADDR_FLAGS0)) begin
        hrdata_r <= {24'h000000, flags0_r};
      end else if (addr_is(haddr, ped_pkg::ADDR_FLAGS1)) begin
        hrdata_r <= {26'h0000000, flags1_r};
      end else begin
        hrdata_r <= '0;
      end
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      noise_filter_clock_select_r <= ped_pkg::NPC_RST;
    end else if (wr_pend_r && addr_is(wr_addr_r, ped_pkg::ADDR_NPC)) begin
      noise_filter_clock_select_r <= hwdata[7:0] & ped_pkg::NPC_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_sel0_r <= ped_pkg::EDGE_SEL_RST;
    end else if (wr_pend_r && addr_is(wr_addr_r, ped_pkg::ADDR_EDGE_SEL0)) begin
      edge_sel0_r <= hwdata[7:0] & ped_pkg::EDGE_SEL0_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_sel1_r <= ped_pkg::EDGE_SEL_RST;
    end else if (wr_pend_r && addr_is(wr_addr_r, ped_pkg::ADDR_EDGE_SEL1)) begin
      edge_sel1_r <= hwdata[7:0];
    end
  end

  // a write cycle to a select register blanks valid edges of its pins
  always_comb begin
    sel_busy = '0;
    nmi_sel_busy = 1'b0;
    if (wr_pend_r && addr_is(wr_addr_r, ped_pkg::ADDR_EDGE_SEL0)) begin
      sel_busy[2:0] = 3'h7;
      nmi_sel_busy = 1'b1;
    end
    if (wr_pend_r && addr_is(wr_addr_r, ped_pkg::ADDR_EDGE_SEL1)) begin
      sel_busy[6:3] = 4'hf;
    end
  end

  // pin n field sits at pin_sel[2n+1:2n]
  assign pin_sel = {edge_sel1_r, edge_sel0_r[7:2]};

  // ---------------- sampling and filters ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  // one shared phase: all slow pins sample on the same cycle
  assign slow_strobe = (div_r == ped_pkg::SLOW_DIV_LAST);

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      // select bit 1 samples on one clock in four
      assign sample_en[gi] = noise_filter_clock_select_r[gi] ? slow_strobe : 1'b1;

      ped_noise_filter #(
        .RUN(ped_pkg::FILTER_RUN)
      ) u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin(filtered_input_pins[gi]),
        .sample_en(sample_en[gi]),
        .level_r(level[gi])
      );

      assign valid[gi] = edge_valid(pin_sel[2*gi+1 -: 2], rise[gi], fall[gi]);
      assign seen[2*gi] = fall[gi];
      assign seen[2*gi+1] = rise[gi];
    end
  endgenerate

  ped_nmi_delay #(
    .CYCLES(NMI_CYCLES)
  ) u_nmi (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(nmi_input_pin),
    .level_r(nmi_level)
  );

  // ---------------- edge detection ----------------
  assign halted = standby_stop || standby_idle;

  // filtered levels start at zero, so a pin already high gives a rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= level;
    end
  end

  // nmi history kept apart: that pin never halts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_prev_r <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_level;
    end
  end

  // standby drops filtered-pin edges; the non-maskable pin is never halted
  assign rise = halted ? '0 : (level & ~prev_r);
  assign fall = halted ? '0 : (~level & prev_r);
  assign nmi_valid = edge_valid({1'b0, edge_sel0_r[0]}, nmi_level & ~nmi_prev_r,
    ~nmi_level & nmi_prev_r);

  // registered so consumers see clean one-cycle pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= '0;
    end else begin
      req_r <= valid & ~sel_busy;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_req_r <= 1'b0;
    end else begin
      nmi_req_r <= nmi_valid && !nmi_sel_busy;
    end
  end

  // ---------------- edge flags ----------------
  // hardware set wins over a software write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags0_r <= ped_pkg::FLAGS_RST;
    end else if (wr_pend_r && addr_is(wr_addr_r, ped_pkg::ADDR_FLAGS0)) begin
      flags0_r <= hwdata[7:0] | seen[7:0];
    end else begin
      flags0_r <= flags0_r | seen[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags1_r <= ped_pkg::FLAGS_RST[5:0];
    end else if (wr_pend_r && addr_is(wr_addr_r, ped_pkg::ADDR_FLAGS1)) begin
      flags1_r <= (hwdata[5:0] & ped_pkg::FLAGS1_MASK[5:0]) | seen[13:8];
    end else begin
      flags1_r <= flags1_r | seen[13:8];
    end
  end

  // ---------------- shared interrupt slots ----------------
  // timer matches pass one register, aligned with the pin requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot0_r <= 1'b0;
    end else begin
      slot0_r <= valid[0] && !sel_busy[0] || timer0_match0_request;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot1_r <= 1'b0;
    end else begin
      slot1_r <= valid[1] && !sel_busy[1] || timer0_match1_request;
    end
  end

  // ---------------- outputs ----------------
  assign nmi_request = nmi_req_r;
  assign ext_request_pin = req_r;
  assign slot0_request = slot0_r;
  assign slot1_request = slot1_r;
  assign nmi_vector = ped_pkg::NMI_VECTOR;
  assign slot0_vector = ped_pkg::SLOT0_VECTOR;
  assign slot1_vector = ped_pkg::SLOT1_VECTOR;
  assign slot0_priority = ped_pkg::SLOT0_PRIO;
  assign slot1_priority = ped_pkg::SLOT1_PRIO;
  assign timer0_capture_trig = req_r[3:0];
  assign adc_start_trig = req_r[4];
  assign tmr2_count_clk = req_r[5];
  assign tmr3_count_clk = req_r[6];
endmodule

// ==== verification/ped_pin_source.sv ====
// signal source model driving the filtered and non-maskable pins
`timescale 1ns/1ns
module ped_pin_source (
  input wire logic hclk,
  input wire logic go,
  input wire logic [2:0] sel,
  input wire logic nmi_sel,
  input wire logic [7:0] width,
  output logic [6:0] filtered_input_pins,
  output logic nmi_input_pin
);
  logic [7:0] cnt_r;
  logic [2:0] sel_r;
  logic nmi_r;
  initial begin
    filtered_input_pins = 7'h00;
    nmi_input_pin = 1'b0;
    cnt_r = 8'h00;
  end
  // width 0 leaves the new level standing, else a pulse of width cycles
  // only commanded pulses, no clock-synchronous noise is injected
  always @(posedge hclk) begin
    if (go || cnt_r == 8'h01) begin
      if (go ? nmi_sel : nmi_r)
        nmi_input_pin <= ~nmi_input_pin;
      else
        filtered_input_pins[go ? sel : sel_r] <=
          ~filtered_input_pins[go ? sel : sel_r];
    end
    if (go) begin
      sel_r <= sel;
      nmi_r <= nmi_sel;
    end
    cnt_r <= go ? width : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
  end
endmodule

// ==== verification/ped_checker_sva.sv ====
// port assertions for the pin edge detect block
`timescale 1ns/1ns
module ped_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic standby_stop,
  input wire logic standby_idle,
  input wire logic timer0_match0_request,
  input wire logic timer0_match1_request,
  input wire logic nmi_request,
  input wire logic [6:0] ext_request_pin,
  input wire logic slot0_request,
  input wire logic slot1_request,
  input wire logic [7:0] nmi_vector,
  input wire logic [7:0] slot0_vector,
  input wire logic [7:0] slot1_vector,
  input wire logic [4:0] slot0_priority,
  input wire logic [4:0] slot1_priority,
  input wire logic [3:0] timer0_capture_trig,
  input wire logic adc_start_trig,
  input wire logic tmr2_count_clk,
  input wire logic tmr3_count_clk
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  assign rd_take = hsel && hready && htrans == ped_pkg::HTRANS_NONSEQ && !hwrite;
  req_pulse_a: assert property (
    ext_request_pin != 7'h00 |=> (ext_request_pin & $past(ext_request_pin)) == 7'h00)
    else $error("edge request longer than one cycle");
  nmi_pulse_a: assert property (nmi_request |=> !nmi_request)
    else $error("nmi request longer than one cycle");
  trig_map_a: assert property (
    {tmr3_count_clk, tmr2_count_clk, adc_start_trig, timer0_capture_trig} == ext_request_pin)
    else $error("consumer trigger differs from pin request");
  slot0_merge_a: assert property (
    slot0_request == (ext_request_pin[0] | $past(timer0_match0_request)))
    else $error("slot0 request not the merge of its sources");
  slot1_merge_a: assert property (
    slot1_request == (ext_request_pin[1] | $past(timer0_match1_request)))
    else $error("slot1 request not the merge of its sources");
  fixed_ids_a: assert property (
    nmi_vector == ped_pkg::NMI_VECTOR && slot0_vector == ped_pkg::SLOT0_VECTOR &&
    slot1_vector == ped_pkg::SLOT1_VECTOR && slot0_priority == ped_pkg::SLOT0_PRIO &&
    slot1_priority == ped_pkg::SLOT1_PRIO)
    else $error("vector or priority output wrong");
  standby_halt_a: assert property (
    (standby_stop || standby_idle) [*3] |-> ext_request_pin == 7'h00)
    else $error("filtered request during standby");
  npc_top_a: assert property (
    rd_take && haddr == ped_pkg::ADDR_NPC |=> hrdata[31:7] == 25'h0000000)
    else $error("filter select read shows bit 7 or above");
  flags1_top_a: assert property (
    rd_take && haddr == ped_pkg::ADDR_FLAGS1 |=> hrdata[31:6] == 26'h0000000)
    else $error("second flag register shows bits 6 or above");
  bus_okay_a: assert property (
    hreadyout && hresp == ped_pkg::HRESP_OKAY)
    else $error("register bus not ready or not okay");
endmodule
bind ped_top ped_checker u_ped_checker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .standby_stop, .standby_idle, .timer0_match0_request,
  .timer0_match1_request,
  .nmi_request, .ext_request_pin, .slot0_request, .slot1_request, .nmi_vector, .slot0_vector,
  .slot1_vector, .slot0_priority, .slot1_priority, .timer0_capture_trig, .adc_start_trig,
  .tmr2_count_clk, .tmr3_count_clk);

// ==== verification/tb_top.sv ====
// self-checking bench: register access, filtering, edge flags and requests
`timescale 1ns/1ns
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, go, nmi_sel, standby_stop, standby_idle, m0, m1;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] sel;
  logic [7:0] width;
  logic [6:0] pins, ext_request_pin;
  logic nmi_pin, nmi_request, slot0_request, slot1_request;
  int req_cnt[8];
  int slot_cnt[2];
  int num_errors, checks, cyc, lat;
  logic [31:0] codes[3] = '{32'h0, 32'h1, 32'h3};
  logic [31:0] want[3] = '{32'h1, 32'h1, 32'h2};
  ped_top #(.NMI_CYCLES(8)) u_ped_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .nmi_input_pin(nmi_pin),
    .filtered_input_pins(pins), .standby_stop(standby_stop), .standby_idle(standby_idle),
    .timer0_match0_request(m0), .timer0_match1_request(m1), .nmi_request(nmi_request),
    .ext_request_pin(ext_request_pin), .slot0_request(slot0_request),
    .slot1_request(slot1_request),
    .nmi_vector(), .slot0_vector(), .slot1_vector(), .slot0_priority(), .slot1_priority(),
    .timer0_capture_trig(), .adc_start_trig(), .tmr2_count_clk(), .tmr3_count_clk());
  ped_pin_source u_ped_pin_source (.hclk(hclk), .go(go), .sel(sel), .nmi_sel(nmi_sel),
    .width(width), .filtered_input_pins(pins), .nmi_input_pin(nmi_pin));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // request counters and the hang guard
  always @(posedge hclk) begin
    for (int k = 0; k < 7; k++) begin
      if (ext_request_pin[k] === 1'b1)
        req_cnt[k]++;
    end
    if (nmi_request === 1'b1)
      req_cnt[7]++;
    if (slot0_request === 1'b1)
      slot_cnt[0]++;
    if (slot1_request === 1'b1)
      slot_cnt[1]++;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic addr_phase(input logic [31:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= ped_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    addr_phase(a, 1'b1);
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic rd_check(input string name, input logic [31:0] a, input logic [31:0] exp);
    addr_phase(a, 1'b0);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    check(name, hrdata, exp);
  endtask
  // p 0..6 filtered pin, 8 the non-maskable pin
  task automatic pulse(input logic [3:0] p, input logic [7:0] w, input int settle);
    go <= 1'b1;
    sel <= p[2:0];
    nmi_sel <= p[3];
    width <= w;
    @(posedge hclk);
    go <= 1'b0;
    repeat (settle) @(posedge hclk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, go, nmi_sel, standby_stop, standby_idle, m0, m1} = 9'h000;
    {haddr, hwdata, htrans, sel, width} = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_check("npc reset", ped_pkg::ADDR_NPC, 32'h0);
    wr(ped_pkg::ADDR_NPC, 8'hff);
    rd_check("npc mask", ped_pkg::ADDR_NPC, 32'h7f);
    rd_check("unmapped", 32'h100, 32'h0);
    wr(ped_pkg::ADDR_NPC, 8'h00);
    $display("test registers done");
    pulse(0, 3, 30);
    rd_check("short pulse", ped_pkg::ADDR_FLAGS0, 32'h0);
    pulse(0, 5, 40);
    rd_check("full pulse", ped_pkg::ADDR_FLAGS0, 32'h3);
    check("fall req", 32'(req_cnt[0]), 32'h1);
    wr(ped_pkg::ADDR_FLAGS0, 8'h00);
    rd_check("cleared", ped_pkg::ADDR_FLAGS0, 32'h0);
    wr(ped_pkg::ADDR_NPC, 8'h01);
    pulse(0, 12, 60);
    rd_check("slow short", ped_pkg::ADDR_FLAGS0, 32'h0);
    pulse(0, 20, 80);
    rd_check("slow long", ped_pkg::ADDR_FLAGS0, 32'h3);
    wr(ped_pkg::ADDR_NPC, 8'h00);
    wr(ped_pkg::ADDR_FLAGS0, 8'h00);
    $display("test filter done");
    wr(ped_pkg::ADDR_EDGE_SEL0, 8'h04);
    pulse(0, 0, 0);
    lat = 0;
    while (ext_request_pin[0] !== 1'b1 && lat < 40) begin
      @(posedge hclk);
      lat++;
    end
    check("latency", 32'(lat >= 6 && lat <= 9), 32'h1);
    pulse(0, 0, 30);
    check("rise only", 32'(req_cnt[0]), 32'h3);
    rd_check("both flags", ped_pkg::ADDR_FLAGS0, 32'h3);
    for (int i = 0; i < 3; i++) begin
      lat = req_cnt[3];
      wr(ped_pkg::ADDR_EDGE_SEL1, codes[i][7:0]);
      pulse(3, 8, 30);
      check("edge code", 32'(req_cnt[3] - lat), want[i]);
    end
    wr(ped_pkg::ADDR_FLAGS1, 8'h00);
    pulse(5, 8, 30);
    rd_check("flags pin5", ped_pkg::ADDR_FLAGS1, 32'h0c);
    $display("test edges done");
    wr(ped_pkg::ADDR_EDGE_SEL0, 8'h01);
    pulse(8, 4, 30);
    check("nmi short", 32'(req_cnt[7]), 32'h0);
    pulse(8, 12, 40);
    check("nmi rise", 32'(req_cnt[7]), 32'h1);
    lat = slot_cnt[0];
    m0 <= 1'b1;
    m1 <= 1'b1;
    @(posedge hclk);
    m0 <= 1'b0;
    m1 <= 1'b0;
    repeat (3) @(posedge hclk);
    check("slot0 match", 32'(slot_cnt[0] - lat), 32'h1);
    check("slot1 match", 32'(slot_cnt[1]), 32'h1);
    standby_stop <= 1'b1;
    lat = req_cnt[1] + req_cnt[2];
    pulse(1, 8, 30);
    pulse(8, 12, 40);
    check("nmi in stop", 32'(req_cnt[7]), 32'h2);
    standby_stop <= 1'b0;
    standby_idle <= 1'b1;
    pulse(2, 8, 30);
    check("standby", 32'(req_cnt[1] + req_cnt[2] - lat), 32'h0);
    standby_idle <= 1'b0;
    repeat (30) @(posedge hclk);
    $display("test nmi and standby done");
    wr(ped_pkg::ADDR_NPC, 8'h7f);
    pulse(2, 0, 5);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (30) @(posedge hclk);
    rd_check("npc rereset", ped_pkg::ADDR_NPC, 32'h0);
    rd_check("high at release", ped_pkg::ADDR_FLAGS0, 32'h20);
    $display("test reset done");
    complete_run();
  end
endmodule
